// ===== logic/ccr_regs.sv
// comparator control register bank for two analog comparators
//
// Functional notes
// - enable bit 7 powers the comparator
// - bit 6 shows live comparator result
// - bit 5 latches rising edges, sticky
// - bit 4 latches falling edges, sticky
// - bits 3:2 select positive hysteresis level
// - bits 1:0 select negative hysteresis level
// - mode bit 5 gates rising interrupt
// - mode bit 4 gates falling interrupt
// - mode bit 7 reserved, reads one
// - mode bits 6, 3:2 read zero
// - mode bits 1:0 set speed and power
// - positive select decode, bits 3:0
// - each comparator owns an input select register
// - comparator outputs feed timer capture
`timescale 1ns/1ps
module ccr_regs
    import ccr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [1:0] cmp_raw,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic [1:0] cmp_enable,
    output logic [3:0] pos_hyst_sel,
    output logic [3:0] neg_hyst_sel,
    output logic [3:0] speed_power_sel,
    output logic [3:0] cmp0_neg_sel,
    output logic [3:0] cmp0_pos_sel,
    output logic [3:0] cmp1_neg_sel,
    output logic [3:0] cmp1_pos_sel,
    output logic [5:0] src_kind,
    output logic [5:0] pos_src_kind,
    output logic [1:0] cmp_irq,
    output logic [1:0] timer_capture_src
);
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic [1:0] irq_q;
    logic [1:0] cap_q;
    logic [1:0] en_q;
    logic [3:0] ph_q;
    logic [3:0] nh_q;
    logic [3:0] sp_q;
    logic [7:0] sel0_q;
    logic [7:0] sel1_q;
    logic [5:0] nkind_q;
    logic [5:0] pkind_q;

    logic [7:0] ctl0, mode0, msel0, ctl1, mode1, msel1;
    logic hit0, hit1, irq0_d, irq1_d;
    logic rise0, fall0, rise1, fall1;

    ccr_channel #(
        .CONTROL_ADDR(CMP0_CONTROL_ADDR),
        .MODE_ADDR(CMP0_MODE_ADDR),
        .SELECT_ADDR(CMP0_INPUT_SELECT_ADDR)
    ) u_ch0 (
        .clk(clk),
        .reset(reset),
        .wr_en(sfr_wr),
        .addr(sfr_addr),
        .wdata(sfr_wdata),
        .result_sync(sync2_q[0]),
        .control_rd(ctl0),
        .mode_rd(mode0),
        .select_rd(msel0),
        .hit(hit0),
        .irq_d(irq0_d),
        .rise_flag(rise0),
        .fall_flag(fall0)
    );

    ccr_channel #(
        .CONTROL_ADDR(CMP1_CONTROL_ADDR),
        .MODE_ADDR(CMP1_MODE_ADDR),
        .SELECT_ADDR(CMP1_INPUT_SELECT_ADDR)
    ) u_ch1 (
        .clk(clk),
        .reset(reset),
        .wr_en(sfr_wr),
        .addr(sfr_addr),
        .wdata(sfr_wdata),
        .result_sync(sync2_q[1]),
        .control_rd(ctl1),
        .mode_rd(mode1),
        .select_rd(msel1),
        .hit(hit1),
        .irq_d(irq1_d),
        .rise_flag(rise1),
        .fall_flag(fall1)
    );

    // select decode shared by both comparators
    function automatic ccr_src_e decode_sel(input logic [3:0] code,
                                            input logic [3:0] pin_last);
        ccr_src_e kind;
        kind = CCR_SRC_RSVD;
        if (code <= pin_last) begin
            kind = CCR_SRC_PIN;
        end else begin
            case (code)
                SEL_TOUCH: kind = CCR_SRC_TOUCH;
                SEL_HALF_SUPPLY: kind = CCR_SRC_HALF;
                SEL_SUPPLY_A: kind = CCR_SRC_SUPPLY_A;
                SEL_SUPPLY_B: kind = CCR_SRC_SUPPLY_B;
                default: kind = CCR_SRC_RSVD;
            endcase
        end
        return kind;
    endfunction : decode_sel

    wire ccr_src_e nk0 = decode_sel(msel0[NEG_SEL_LSB +: 4], NEG_PIN_LAST);
    wire ccr_src_e nk1 = decode_sel(msel1[NEG_SEL_LSB +: 4], NEG_PIN_LAST);
    wire ccr_src_e pk0 = decode_sel(msel0[POS_SEL_LSB +: 4], POS_PIN_LAST);
    wire ccr_src_e pk1 = decode_sel(msel1[POS_SEL_LSB +: 4], POS_PIN_LAST);

    wire logic any_hit = hit0 || hit1;
    // read mux; unmapped addresses read zero
    wire logic [7:0] rd_mux =
        (sfr_addr == CMP0_CONTROL_ADDR) ? ctl0 :
        (sfr_addr == CMP1_CONTROL_ADDR) ? ctl1 :
        (sfr_addr == CMP0_MODE_ADDR) ? mode0 :
        (sfr_addr == CMP1_MODE_ADDR) ? mode1 :
        (sfr_addr == CMP0_INPUT_SELECT_ADDR) ? msel0 :
        (sfr_addr == CMP1_INPUT_SELECT_ADDR) ? msel1 : 8'h00;

    // analog result is asynchronous: two flops first
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_q <= 2'b00;
            sync2_q <= 2'b00;
        end else begin
            sync1_q <= cmp_raw;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            rdata_q <= sfr_rd ? rd_mux : 8'h00;
            hit_q <= (sfr_rd || sfr_wr) && any_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 2'b00;
        end else begin
            irq_q <= {irq1_d, irq0_d};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cap_q <= 2'b00;
        end else begin
            cap_q <= sync2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            en_q <= {2{CONTROL_RESET[EN_BIT]}};
            ph_q <= {2{CONTROL_RESET[POS_HYST_LSB +: 2]}};
            nh_q <= {2{CONTROL_RESET[NEG_HYST_LSB +: 2]}};
            sp_q <= {MODE_RESET[SPEED_LSB +: 2], MODE_RESET[SPEED_LSB +: 2]};
            sel0_q <= INPUT_SELECT_RESET;
            sel1_q <= INPUT_SELECT_RESET;
            nkind_q <= {CCR_SRC_SUPPLY_B, CCR_SRC_SUPPLY_B};
            pkind_q <= {CCR_SRC_SUPPLY_B, CCR_SRC_SUPPLY_B};
        end else begin
            en_q <= {ctl1[EN_BIT], ctl0[EN_BIT]};
            ph_q <= {ctl1[POS_HYST_LSB +: 2], ctl0[POS_HYST_LSB +: 2]};
            nh_q <= {ctl1[NEG_HYST_LSB +: 2], ctl0[NEG_HYST_LSB +: 2]};
            sp_q <= {mode1[SPEED_LSB +: 2], mode0[SPEED_LSB +: 2]};
            sel0_q <= msel0;
            sel1_q <= msel1;
            nkind_q <= {nk1, nk0};
            pkind_q <= {pk1, pk0};
        end
    end

    assign sfr_rdata = rdata_q;
    assign sfr_hit = hit_q;
    assign cmp_enable = en_q;
    assign pos_hyst_sel = ph_q;
    assign neg_hyst_sel = nh_q;
    assign speed_power_sel = sp_q;
    assign cmp0_neg_sel = sel0_q[NEG_SEL_LSB +: 4];
    assign cmp0_pos_sel = sel0_q[POS_SEL_LSB +: 4];
    assign cmp1_neg_sel = sel1_q[NEG_SEL_LSB +: 4];
    assign cmp1_pos_sel = sel1_q[POS_SEL_LSB +: 4];
    assign src_kind = nkind_q;
    assign pos_src_kind = pkind_q;
    assign cmp_irq = irq_q;
    assign timer_capture_src = cap_q;

    // synchronised rising edge sets flag on the next cycle
    chk_rise_flag_set: assert property (
        @(posedge clk) disable iff (reset)
        (sync2_q[1] && !$past(sync2_q[1])) |=> rise1)
        else $error("rise flag not set");
    chk_fall_flag_set: assert property (
        @(posedge clk) disable iff (reset)
        (!sync2_q[0] && $past(sync2_q[0])) |=> fall0)
        else $error("fall flag not set");
    // flags never drop without a write
    chk_flag_sticky: assert property (
        @(posedge clk) disable iff (reset)
        ($past(rise0) && !$past(sfr_wr)) |-> rise0)
        else $error("rise flag dropped");
    chk_result_bit: assert property (
        @(posedge clk) disable iff (reset)
        (sfr_rd && sfr_addr == CMP1_CONTROL_ADDR) |=>
        sfr_rdata[RESULT_BIT] == $past(sync2_q[1]))
        else $error("result bit mismatch");
    chk_mode_rsvd: assert property (
        @(posedge clk) disable iff (reset)
        (sfr_rd && sfr_addr == CMP0_MODE_ADDR) |=>
        sfr_rdata[MODE_RSVD_BIT] && sfr_rdata[6] == 1'b0 &&
        sfr_rdata[3:2] == 2'b00)
        else $error("mode reserved bits wrong");
    chk_irq_gate: assert property (
        @(posedge clk) disable iff (reset)
        !(rise1 && mode1[RISE_IE_BIT]) && !(fall1 && mode1[FALL_IE_BIT])
        |-> !cmp_irq[1])
        else $error("irq without enabled flag");
    // enable write reaches analog within two cycles
    chk_enable_out: assert property (
        @(posedge clk) disable iff (reset)
        (sfr_wr && sfr_addr == CMP0_CONTROL_ADDR) |-> ##2
        cmp_enable[0] == $past(sfr_wdata[EN_BIT], 2))
        else $error("enable not forwarded");
    chk_speed_out: assert property (
        @(posedge clk) disable iff (reset)
        (sfr_wr && sfr_addr == CMP1_MODE_ADDR) |-> ##2
        speed_power_sel[3:2] == $past(sfr_wdata[1:0], 2))
        else $error("speed not forwarded");
    cov_rise: cover property (@(posedge clk) rise0 && mode0[RISE_IE_BIT]);
    cov_irq1: cover property (@(posedge clk) cmp_irq[1]);
    cov_clear: cover property (@(posedge clk)
        $fell(fall1) ##1 !fall1);
endmodule : ccr_regs

// ===== common/ccr_pkg.sv
// constants for the comparator control register bank
package ccr_pkg;
    // register addresses on the special function register bus
    localparam logic [7:0] CMP0_CONTROL_ADDR = 8'h9b;
    localparam logic [7:0] CMP1_CONTROL_ADDR = 8'h9a;
    localparam logic [7:0] CMP0_MODE_ADDR = 8'h9d;
    localparam logic [7:0] CMP1_MODE_ADDR = 8'h9c;
    localparam logic [7:0] CMP0_INPUT_SELECT_ADDR = 8'h9f;
    localparam logic [7:0] CMP1_INPUT_SELECT_ADDR = 8'h9e;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h82;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'hff;
    // control register field positions
    localparam int EN_BIT = 7;
    localparam int RESULT_BIT = 6;
    localparam int RISE_BIT = 5;
    localparam int FALL_BIT = 4;
    localparam int POS_HYST_LSB = 2;
    localparam int NEG_HYST_LSB = 0;
    // mode register field positions
    localparam int MODE_RSVD_BIT = 7;
    localparam int RISE_IE_BIT = 5;
    localparam int FALL_IE_BIT = 4;
    localparam int SPEED_LSB = 0;
    // input select field positions
    localparam int NEG_SEL_LSB = 4;
    localparam int POS_SEL_LSB = 0;
    // input select codes
    localparam logic [3:0] SEL_TOUCH = 4'hc;
    localparam logic [3:0] SEL_HALF_SUPPLY = 4'hd;
    localparam logic [3:0] SEL_SUPPLY_A = 4'he;
    localparam logic [3:0] SEL_SUPPLY_B = 4'hf;
    localparam logic [3:0] NEG_PIN_LAST = 4'h6;
    localparam logic [3:0] POS_PIN_LAST = 4'h7;
    // source selected by an input select field
    typedef enum logic [2:0] {
        CCR_SRC_PIN = 3'b000,
        CCR_SRC_TOUCH = 3'b001,
        CCR_SRC_HALF = 3'b010,
        CCR_SRC_SUPPLY_A = 3'b011,
        CCR_SRC_SUPPLY_B = 3'b100,
        CCR_SRC_RSVD = 3'b101
    } ccr_src_e;
endpackage : ccr_pkg

// ===== logic/ccr_channel.sv
// one comparator channel: control, mode and input select registers
`timescale 1ns/1ps
module ccr_channel
    import ccr_pkg::*;
#(
    parameter logic [7:0] CONTROL_ADDR = 8'h9a,
    parameter logic [7:0] MODE_ADDR = 8'h9c,
    parameter logic [7:0] SELECT_ADDR = 8'h9e
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic result_sync,
    output logic [7:0] control_rd,
    output logic [7:0] mode_rd,
    output logic [7:0] select_rd,
    output logic hit,
    output logic irq_d,
    output logic rise_flag,
    output logic fall_flag
);
    logic en_q;
    logic [1:0] pos_hyst_q;
    logic [1:0] neg_hyst_q;
    logic rise_q;
    logic fall_q;
    logic rise_ie_q;
    logic fall_ie_q;
    logic [1:0] speed_q;
    logic [7:0] select_q;
    logic prev_q;

    // distinct addresses, else one write lands in two registers
    if (CONTROL_ADDR == MODE_ADDR || CONTROL_ADDR == SELECT_ADDR ||
        MODE_ADDR == SELECT_ADDR) begin : g_bad_addr
        $error("channel register addresses must differ");
    end

    wire logic wr_ctl = wr_en && (addr == CONTROL_ADDR);
    wire logic wr_mode = wr_en && (addr == MODE_ADDR);
    wire logic wr_sel = wr_en && (addr == SELECT_ADDR);
    // edge seen only on already synchronised result
    wire logic rise_evt = result_sync && !prev_q;
    wire logic fall_evt = !result_sync && prev_q;
    // set wins over a clear in one cycle
    wire logic rise_d = rise_evt || (wr_ctl ? wdata[RISE_BIT] : rise_q);
    wire logic fall_d = fall_evt || (wr_ctl ? wdata[FALL_BIT] : fall_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            en_q <= CONTROL_RESET[EN_BIT];
            pos_hyst_q <= CONTROL_RESET[POS_HYST_LSB +: 2];
            neg_hyst_q <= CONTROL_RESET[NEG_HYST_LSB +: 2];
            rise_q <= CONTROL_RESET[RISE_BIT];
            fall_q <= CONTROL_RESET[FALL_BIT];
            rise_ie_q <= MODE_RESET[RISE_IE_BIT];
            fall_ie_q <= MODE_RESET[FALL_IE_BIT];
            speed_q <= MODE_RESET[SPEED_LSB +: 2];
            select_q <= INPUT_SELECT_RESET;
            prev_q <= 1'b0;
        end else begin
            prev_q <= result_sync;
            rise_q <= rise_d;
            fall_q <= fall_d;
            if (wr_ctl) begin
                en_q <= wdata[EN_BIT];
                pos_hyst_q <= wdata[POS_HYST_LSB +: 2];
                neg_hyst_q <= wdata[NEG_HYST_LSB +: 2];
            end
            // speed field, gates kept with it
            if (wr_mode) begin
                rise_ie_q <= wdata[RISE_IE_BIT];
                fall_ie_q <= wdata[FALL_IE_BIT];
                speed_q <= wdata[SPEED_LSB +: 2];
            end
            if (wr_sel) begin
                select_q <= wdata;
            end
        end
    end

    assign control_rd = {en_q, result_sync, rise_q, fall_q,
                         pos_hyst_q, neg_hyst_q};
    // reserved reads one, unused read zero
    assign mode_rd = {1'b1, 1'b0, rise_ie_q, fall_ie_q, 2'b00, speed_q};
    assign select_rd = select_q;
    assign hit = (addr == CONTROL_ADDR) || (addr == MODE_ADDR) ||
                 (addr == SELECT_ADDR);
    assign irq_d = (rise_d && (wr_mode ? wdata[RISE_IE_BIT] : rise_ie_q)) ||
                   (fall_d && (wr_mode ? wdata[FALL_IE_BIT] : fall_ie_q));
    assign rise_flag = rise_q;
    assign fall_flag = fall_q;
endmodule : ccr_channel

// ===== bench/ccr_cmp_model.sv
// behavioural analog comparator pair driving the raw results
`timescale 1ns/1ps
module ccr_cmp_model (
    input wire logic [1:0] cmp_enable,
    input wire logic [1:0] level_req,
    output logic [1:0] cmp_raw
);
    // disabled core is powered down, output low
    // small delay stands in for analog settling, not a clock edge
    assign #2 cmp_raw = level_req & cmp_enable;
endmodule : ccr_cmp_model

// ===== bench/ccr_regs_bench.sv
// self-checking bench for the comparator register bank
`timescale 1ns/1ps
module ccr_regs_bench;
    import ccr_pkg::*;
    logic clk, reset, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic sfr_hit;
    logic [1:0] cmp_raw, cmp_enable, cmp_irq, timer_capture_src, lvl;
    logic [3:0] pos_hyst_sel, neg_hyst_sel, speed_power_sel;
    logic [3:0] cmp0_neg_sel, cmp0_pos_sel, cmp1_neg_sel, cmp1_pos_sel;
    logic [5:0] src_kind, pos_src_kind;
    logic [7:0] m_ctl [2];
    logic [7:0] m_mode [2];
    logic [7:0] m_sel [2];
    logic [31:0] lfsr_q;
    logic [7:0] rnd_addr, rnd_data;
    int n_mismatch, checked;

    ccr_regs ccr_regs_inst (.clk(clk), .reset(reset), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .cmp_raw(cmp_raw), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .cmp_enable(cmp_enable), .pos_hyst_sel(pos_hyst_sel),
        .neg_hyst_sel(neg_hyst_sel), .speed_power_sel(speed_power_sel),
        .cmp0_neg_sel(cmp0_neg_sel), .cmp0_pos_sel(cmp0_pos_sel),
        .cmp1_neg_sel(cmp1_neg_sel), .cmp1_pos_sel(cmp1_pos_sel),
        .src_kind(src_kind), .pos_src_kind(pos_src_kind),
        .cmp_irq(cmp_irq), .timer_capture_src(timer_capture_src));
    ccr_cmp_model ccr_cmp_model_inst (.cmp_enable(cmp_enable),
        .level_req(lvl), .cmp_raw(cmp_raw));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] addr_of(int n, int r);
        if (r == 0) return n ? CMP1_CONTROL_ADDR : CMP0_CONTROL_ADDR;
        if (r == 1) return n ? CMP1_MODE_ADDR : CMP0_MODE_ADDR;
        return n ? CMP1_INPUT_SELECT_ADDR : CMP0_INPUT_SELECT_ADDR;
    endfunction : addr_of

    function automatic logic [2:0] kind(logic [3:0] c, logic [3:0] last);
        if (c <= last) return CCR_SRC_PIN;
        case (c)
            4'hc: return CCR_SRC_TOUCH;
            4'hd: return CCR_SRC_HALF;
            4'he: return CCR_SRC_SUPPLY_A;
            4'hf: return CCR_SRC_SUPPLY_B;
            default: return CCR_SRC_RSVD;
        endcase
    endfunction : kind

    function automatic logic res(int n);
        return lvl[n] & m_ctl[n][7];
    endfunction : res

    function automatic logic [7:0] exp_rd(logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int n = 0; n < 2; n++) begin
            if (a == addr_of(n, 0)) v = {m_ctl[n][7], res(n), m_ctl[n][5:0]};
            if (a == addr_of(n, 1)) v = m_mode[n];
            if (a == addr_of(n, 2)) v = m_sel[n];
        end
        return v;
    endfunction : exp_rd

    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
        for (int n = 0; n < 2; n++) begin
            if (a == addr_of(n, 0)) m_ctl[n] = {d[7], 1'b0, d[5:0]};
            // reserved reads one, unused bits ignored
            if (a == addr_of(n, 1)) m_mode[n] = (d & 8'h33) | 8'h80;
            if (a == addr_of(n, 2)) m_sel[n] = d;
        end
    endtask : wr

    task automatic rd_chk(logic [7:0] a);
        logic hit_exp;
        @(posedge clk);
        #1;
        sfr_rd = 1'b1;
        sfr_addr = a;
        @(posedge clk);
        #1;
        sfr_rd = 1'b0;
        chk("sfr_rdata", sfr_rdata, exp_rd(a));
        hit_exp = (a >= CMP1_CONTROL_ADDR) && (a <= CMP0_INPUT_SELECT_ADDR);
        chk("sfr_hit", {7'h0, sfr_hit}, {7'h0, hit_exp});
    endtask : rd_chk

    task automatic check_outs();
        logic [1:0] e_en, e_irq, e_res;
        logic [3:0] e_ph, e_nh, e_sp;
        logic [5:0] e_nk, e_pk;
        repeat (3) @(posedge clk);
        #1;
        for (int n = 0; n < 2; n++) begin
            e_en[n] = m_ctl[n][7];
            e_res[n] = res(n);
            e_irq[n] = (m_ctl[n][5] & m_mode[n][5]) |
                       (m_ctl[n][4] & m_mode[n][4]);
            e_ph[2*n+:2] = m_ctl[n][3:2];
            e_nh[2*n+:2] = m_ctl[n][1:0];
            e_sp[2*n+:2] = m_mode[n][1:0];
            e_nk[3*n+:3] = kind(m_sel[n][7:4], NEG_PIN_LAST);
            e_pk[3*n+:3] = kind(m_sel[n][3:0], POS_PIN_LAST);
        end
        chk("cmp_enable", {6'h0, cmp_enable}, {6'h0, e_en});
        chk("pos_hyst_sel", {4'h0, pos_hyst_sel}, {4'h0, e_ph});
        chk("neg_hyst_sel", {4'h0, neg_hyst_sel}, {4'h0, e_nh});
        chk("speed_power_sel", {4'h0, speed_power_sel}, {4'h0, e_sp});
        chk("cmp0_sel", {cmp0_neg_sel, cmp0_pos_sel}, m_sel[0]);
        chk("cmp1_sel", {cmp1_neg_sel, cmp1_pos_sel}, m_sel[1]);
        chk("src_kind", {2'h0, src_kind}, {2'h0, e_nk});
        chk("pos_src_kind", {2'h0, pos_src_kind}, {2'h0, e_pk});
        chk("cmp_irq", {6'h0, cmp_irq}, {6'h0, e_irq});
        chk("timer_capture_src", 8'(timer_capture_src), 8'(e_res));
    endtask : check_outs

    task automatic set_level(int n, logic v);
        logic was;
        was = res(n);
        @(posedge clk);
        #1;
        lvl[n] = v;
        repeat (6) @(posedge clk);
        if (!was && res(n)) m_ctl[n][5] = 1'b1;
        if (was && !res(n)) m_ctl[n][4] = 1'b1;
    endtask : set_level

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        lvl = 2'b00;
        n_mismatch = 0;
        checked = 0;
        lfsr_q = 32'hb2bf;
        for (int n = 0; n < 2; n++) begin
            m_ctl[n] = CONTROL_RESET;
            m_mode[n] = MODE_RESET;
            m_sel[n] = INPUT_SELECT_RESET;
        end
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        for (int r = 0; r < 6; r++) rd_chk(addr_of(r % 2, r / 2));
        rd_chk(8'h99);
        rd_chk(8'ha0);
        check_outs();
        // random traffic, unmapped writes must leave registers alone
        repeat (24) begin
            lfsr_q = lfsr_next(lfsr_q);
            rnd_addr = addr_of(lfsr_q[0], lfsr_q[3:1] % 3);
            rnd_data = lfsr_q[15:8];
            // software keeps the reserved mode bit at one
            if (rnd_addr == CMP0_MODE_ADDR || rnd_addr == CMP1_MODE_ADDR) begin
                rnd_data[MODE_RSVD_BIT] = 1'b1;
            end
            wr(rnd_addr, rnd_data);
            wr(lfsr_q[4] ? 8'h99 : 8'ha0, lfsr_q[23:16]);
            for (int r = 0; r < 6; r++) rd_chk(addr_of(r % 2, r / 2));
            check_outs();
        end
        // every select, hysteresis and speed code on both comparators
        for (int c = 0; c < 32; c++) begin
            wr(addr_of(c % 2, 2), {c[4:1], c[4:1]});
            wr(addr_of(c % 2, 0), {4'h0, c[2:1], c[4:3]});
            wr(addr_of(c % 2, 1), {6'h20, c[2:1]});
            check_outs();
        end
        // edges with each combination of interrupt enables
        for (int n = 0; n < 2; n++) begin
            for (int ie = 0; ie < 4; ie++) begin
                wr(addr_of(n, 1), {2'b10, ie[1:0], 4'h0});
                wr(addr_of(n, 0), 8'h80);
                set_level(n, 1'b1);
                rd_chk(addr_of(n, 0));
                check_outs();
                // rise flag stays after the fall
                set_level(n, 1'b0);
                rd_chk(addr_of(n, 0));
                check_outs();
                wr(addr_of(n, 0), 8'h80);
                rd_chk(addr_of(n, 0));
                check_outs();
            end
            wr(addr_of(n, 0), 8'h00);
        end
        test_done();
    end
endmodule : ccr_regs_bench
